// File: src/two_wire_eeprom_slave.sv
module two_wire_eeprom_slave #(
  parameter int unsigned PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
  // clock and reset
  input  wire logic CLOCK_IN,
  input  wire logic RST_IN,
  // two-wire bus
  input  wire logic SCL_IN,
  input  wire logic SDA_IN,
  output logic      SDA_OUT,
  output logic      SDA_OE_OUT,
  // straps and status
  input  wire logic CHIP_SELECT_STRAP_IN,
  input  wire logic WRITE_PROTECT_IN,
  output logic      BUSY_OUT
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_DEV_ACK, ST_WADDR, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
  } state_t;

  state_t                state_q;
  logic [2:0]            scl_s_q, sda_s_q;
  eeprom_pkg::bus_lvl_t  lvl_q, lvl_prev_q;
  logic                  scl_rise, scl_fall, start_det, stop_det;
  logic [3:0]            bit_cnt_q;
  logic [7:0]            shift_q;
  logic                  rw_q, ack_ok_q, wr_dirty_q;
  logic [9:0]            addr_q;
  logic [7:0]            page_q [0:eeprom_pkg::PAGE_BYTES-1];
  logic [15:0]           page_vld_q;
  logic [31:0]           prog_cnt_q;
  logic [3:0]            commit_idx_q;
  logic                  committing_q;
  logic [7:0]            mem_rdata;
  logic                  sda_low_q;
  eeprom_pkg::wr_word_t  buf_q [0:1];
  logic [1:0]            buf_cnt_q;
  logic                  buf_wr, buf_rd;
  logic                  busy;
  logic [2:0]            strap_s_q, wp_s_q;
  logic                  strap_q, wp_q;
  logic                  dev_match, commit_step;
  logic                  buf_widx;

  // pin synchronisers; second and third flops must agree
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      scl_s_q <= 3'b111;
      sda_s_q <= 3'b111;
    end else begin
      scl_s_q <= {scl_s_q[1:0], SCL_IN};
      sda_s_q <= {sda_s_q[1:0], SDA_IN};
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      lvl_q      <= '1;
      lvl_prev_q <= '1;
    end else begin
      if (scl_s_q[1] == scl_s_q[2]) begin
        lvl_q.scl <= scl_s_q[2];
      end
      if (sda_s_q[1] == sda_s_q[2]) begin
        lvl_q.sda <= sda_s_q[2];
      end
      lvl_prev_q <= lvl_q;
    end
  end

  // strap and protect pins, filtered like the bus pins
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      strap_s_q <= 3'b000;
      wp_s_q    <= 3'b111;
    end else begin
      strap_s_q <= {strap_s_q[1:0], CHIP_SELECT_STRAP_IN};
      wp_s_q    <= {wp_s_q[1:0], WRITE_PROTECT_IN};
    end
  end

  // protect held high through reset so no stray write lands
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      strap_q <= 1'b0;
      wp_q    <= 1'b1;
    end else begin
      if (strap_s_q[1] == strap_s_q[2]) begin
        strap_q <= strap_s_q[2];
      end
      if (wp_s_q[1] == wp_s_q[2]) begin
        wp_q <= wp_s_q[2];
      end
    end
  end

  assign scl_rise  = lvl_q.scl & ~lvl_prev_q.scl;
  assign scl_fall  = ~lvl_q.scl & lvl_prev_q.scl;
  // framing conditions from sda moving under high scl
  assign start_det = lvl_q.scl & lvl_prev_q.scl & lvl_prev_q.sda & ~lvl_q.sda;
  assign stop_det  = lvl_q.scl & lvl_prev_q.scl & ~lvl_prev_q.sda & lvl_q.sda;
  assign busy      = (prog_cnt_q != 32'h0000_0000) | committing_q | (buf_cnt_q != 2'd0);
  assign BUSY_OUT  = busy;
  // address byte taken on type code, strap and idle array
  assign dev_match = (shift_q[7:4] == eeprom_pkg::TYPE_CODE) &
                     (shift_q[3] == strap_q) & ~busy;

  // serial protocol machine
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      rw_q      <= 1'b0;
      ack_ok_q  <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (start_det) begin
      state_q   <= busy ? ST_IDLE : ST_DEV;
      bit_cnt_q <= 4'h0;
      sda_low_q <= 1'b0;
    end else if (stop_det) begin
      state_q   <= ST_IDLE;
      sda_low_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          sda_low_q <= 1'b0;
        end
        ST_DEV, ST_WADDR, ST_WDATA: begin
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], lvl_q.sda};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          if (scl_fall && bit_cnt_q == 4'h8) begin
            bit_cnt_q <= 4'h0;
            if (state_q == ST_DEV) begin
              ack_ok_q  <= dev_match;
              rw_q      <= shift_q[0];
              sda_low_q <= dev_match;
              state_q  <= ST_DEV_ACK;
            end else begin
              sda_low_q <= 1'b1;
              state_q   <= ST_WACK;
            end
          end
        end
        ST_DEV_ACK, ST_WACK: begin
          if (scl_fall) begin
            sda_low_q <= 1'b0;
            if (state_q == ST_DEV_ACK && !ack_ok_q) begin
              state_q <= ST_IDLE;
            end else if (state_q == ST_DEV_ACK && rw_q) begin
              state_q   <= ST_RDATA;
              sda_low_q <= ~mem_rdata[7];
              shift_q   <= {mem_rdata[6:0], 1'b1};
            end else if (state_q == ST_DEV_ACK) begin
              state_q <= ST_WADDR;
            end else begin
              state_q <= ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          if (scl_fall) begin
            if (bit_cnt_q == 4'h8) begin
              bit_cnt_q <= 4'h0;
              sda_low_q <= 1'b0;
              state_q   <= ST_RACK;
            end else begin
              sda_low_q <= ~shift_q[7];
              shift_q   <= {shift_q[6:0], 1'b1};
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            ack_ok_q <= ~lvl_q.sda;
          end
          if (scl_fall) begin
            if (ack_ok_q) begin
              state_q   <= ST_RDATA;
              sda_low_q <= ~mem_rdata[7];
              shift_q   <= {mem_rdata[6:0], 1'b1};
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // open-drain: only ever drive low
  assign SDA_OUT    = 1'b0;
  assign SDA_OE_OUT = sda_low_q;

  // address counter
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      addr_q <= eeprom_pkg::ADDR_RST;
    end else if (!start_det && !stop_det) begin
      if (state_q == ST_DEV && scl_fall && bit_cnt_q == 4'h8 && !shift_q[0] && dev_match) begin
        addr_q[9:8] <= shift_q[2:1];
      end else if (state_q == ST_WADDR && scl_fall && bit_cnt_q == 4'h8) begin
        addr_q[7:0] <= shift_q;
      end else if (state_q == ST_WDATA && scl_fall && bit_cnt_q == 4'h8) begin
        addr_q[3:0] <= addr_q[3:0] + 4'h1;
      end else if (state_q == ST_DEV_ACK && scl_fall && rw_q && ack_ok_q) begin
        addr_q <= addr_q + 10'h001;
      end else if (state_q == ST_RACK && scl_fall && ack_ok_q) begin
        addr_q <= addr_q + 10'h001;
      end
    end
  end

  // page buffer, later bytes overwrite by pointer wrap
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      page_vld_q <= 16'h0000;
      wr_dirty_q <= 1'b0;
    end else if (state_q == ST_WDATA && scl_fall && bit_cnt_q == 4'h8 && !start_det) begin
      page_q[addr_q[3:0]]     <= shift_q;
      page_vld_q[addr_q[3:0]] <= 1'b1;
      wr_dirty_q              <= 1'b1;
    end else if (start_det && !committing_q) begin
      page_vld_q <= 16'h0000;
      wr_dirty_q <= 1'b0;
    end else if (commit_step && commit_idx_q == 4'hf) begin
      page_vld_q <= 16'h0000;
      wr_dirty_q <= 1'b0;
    end
  end

  // commit walk over the page at stop
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      committing_q <= 1'b0;
      commit_idx_q <= 4'h0;
    end else if (!committing_q) begin
      if (stop_det && wr_dirty_q) begin
        committing_q <= 1'b1;
        commit_idx_q <= 4'h0;
      end
    end else if (commit_step) begin
      commit_idx_q <= commit_idx_q + 4'h1;
      if (commit_idx_q == 4'hf) begin
        committing_q <= 1'b0;
      end
    end
  end

  // two-entry buffer between page and array; drain continues during protect, array write masked
  assign buf_wr = committing_q & page_vld_q[commit_idx_q] & (buf_cnt_q != 2'd2);
  assign buf_rd = (buf_cnt_q != 2'd0);
  // pointer moves on a stored word or a skipped empty slot
  assign commit_step = committing_q & (buf_wr | ~page_vld_q[commit_idx_q]);
  // slot that a new word lands in, after this cycle's drain
  assign buf_widx = buf_rd ? (buf_cnt_q == 2'd2) : (buf_cnt_q != 2'd0);

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      buf_cnt_q <= 2'd0;
    end else begin
      if (buf_wr && !buf_rd) begin
        buf_cnt_q <= buf_cnt_q + 2'd1;
      end else if (buf_rd && !buf_wr) begin
        buf_cnt_q <= buf_cnt_q - 2'd1;
      end
      if (buf_rd) begin
        buf_q[0] <= buf_q[1];
      end
      if (buf_wr) begin
        buf_q[buf_widx] <= '{addr: {addr_q[9:4], commit_idx_q}, data: page_q[commit_idx_q]};
      end
    end
  end

  // self-timed program cycle
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      prog_cnt_q <= 32'h0000_0000;
    end else if (committing_q) begin
      prog_cnt_q <= PROG_CYCLES;
    end else if (prog_cnt_q != 32'h0000_0000) begin
      prog_cnt_q <= prog_cnt_q - 32'h0000_0001;
    end
  end

  eeprom_mem u_mem (
    .clk_in    (CLOCK_IN),
    .we_in     (buf_rd & ~wp_q),
    .waddr_in  (buf_q[0].addr),
    .wdata_in  (buf_q[0].data),
    .raddr_in  (addr_q),
    .rdata_out (mem_rdata)
  );
endmodule : two_wire_eeprom_slave

// File: src/eeprom_pkg.sv
package eeprom_pkg;
  localparam int unsigned ADDR_W        = 10;
  localparam int unsigned DEPTH         = 1024;
  localparam int unsigned PAGE_BYTES    = 16;
  localparam logic [3:0]  TYPE_CODE     = 4'ha;
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned PROG_TIME_US  = 3000;
  localparam int unsigned PROG_CYCLES   = (PROG_TIME_US * (CLK_HZ / 1_000_000));
  localparam int unsigned BIT_CNT_RST   = 0;
  localparam logic [9:0]  ADDR_RST      = 10'h000;

  // one byte queued for the array write
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] data;
  } wr_word_t;

  // pin samples after synchronisation
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lvl_t;
endpackage : eeprom_pkg

// File: src/eeprom_mem.sv
module eeprom_mem (
  // clock only, no reset
  input  wire logic        clk_in,
  // write port
  input  wire logic        we_in,
  input  wire logic [9:0]  waddr_in,
  input  wire logic [7:0]  wdata_in,
  // read port
  input  wire logic [9:0]  raddr_in,
  output logic      [7:0]  rdata_out
);
  logic [7:0] mem_q [0:eeprom_pkg::DEPTH-1];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    rdata_out <= mem_q[raddr_in];
  end
endmodule : eeprom_mem

// File: dv/two_wire_eeprom_slave_sva.sv
module two_wire_eeprom_slave_sva #(
  parameter int unsigned PROG_CYCLES = 50
) (
  // watched ports
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_OUT,
  input wire logic BUSY_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  int unsigned cnt_q;
  // busy length count
  always_ff @(posedge CLOCK_IN) begin
    cnt_q <= (RST_IN || !BUSY_OUT) ? '0 : cnt_q + 1;
  end
  sequence edge_s(logic lvl);
    SCL_IN && $past(SCL_IN) && $changed(SDA_IN) && SDA_IN == lvl;
  endsequence
  od_low_a: assert property (SDA_OE_OUT |-> !SDA_OUT) else $error("sda high");
  reset_idle_a: assert property (disable iff (1'b0)
    RST_IN |=> !SDA_OE_OUT && !BUSY_OUT) else $error("active in reset");
  low_hold_a: assert property ($rose(SDA_OE_OUT) |-> SDA_OE_OUT[*6])
    else $error("low short");
  rel_hold_a: assert property ($fell(SDA_OE_OUT) |-> !SDA_OE_OUT[*6])
    else $error("release short");
  busy_mute_a: assert property (BUSY_OUT |-> !SDA_OE_OUT) else $error("ack when busy");
  busy_len_a: assert property ($fell(BUSY_OUT) |-> cnt_q >= PROG_CYCLES)
    else $error("busy short");
  start_mute_a: assert property (edge_s(1'b0) |=> !SDA_OE_OUT[*8])
    else $error("drive at start");
  stop_mute_a: assert property (edge_s(1'b1) |=> !SDA_OE_OUT[*8])
    else $error("drive at stop");
  ack_c: cover property ($rose(SDA_OE_OUT));
  busy_c: cover property ($fell(BUSY_OUT));
  start_c: cover property (edge_s(1'b0));
endmodule : two_wire_eeprom_slave_sva

bind two_wire_eeprom_slave two_wire_eeprom_slave_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (
  .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .BUSY_OUT(BUSY_OUT));

// File: dv/two_wire_master.sv
module two_wire_master (
  // bus lines
  output logic       scl_out,
  output logic       sda_out,
  input  wire logic  sda_in,
  // observed results
  output logic [7:0] obs_out,
  output logic       tgl_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    obs_out = 8'h00;
    tgl_out = 1'b0;
  end
  // data moves only while scl low
  task automatic bit_t(input logic b, output logic r);
    #40 sda_out = b;
    #200 scl_out = 1'b1;
    #40 r = sda_in;
    #40 scl_out = 1'b0;
  endtask : bit_t
  task automatic start_c();
    logic r;
    #240 sda_out = 1'b1;
    for (int i = 0; i < 9 && sda_in !== 1'b1; i++) bit_t(1'b1, r);
    #40 scl_out = 1'b1;
    #160 sda_out = 1'b0;
    #160 scl_out = 1'b0;
  endtask : start_c
  task automatic stop_c();
    #240 sda_out = 1'b0;
    #40 scl_out = 1'b1;
    #160 sda_out = 1'b1;
    #240;
  endtask : stop_c
  task automatic tx(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_t(d[i], r); // msb first
    bit_t(1'b1, r);
    obs_out = {7'h00, r};
    tgl_out = ~tgl_out;
  endtask : tx
  task automatic rx(input logic last);
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) bit_t(1'b1, d[i]);
    obs_out = d;
    tgl_out = ~tgl_out;
    bit_t(last, d[0]); // low asks for more, high ends
  endtask : rx
endmodule : two_wire_master

// File: dv/tb_two_wire_eeprom_slave.sv
module tb_two_wire_eeprom_slave;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned PROG = 100;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        strap = 1'b0;
  logic        wp = 1'b0;
  logic        scl, m_sda, sdo, oe, busy, tgl;
  logic [7:0]  obs;
  logic [7:0]  mem [1024];
  logic [7:0]  exp_q [$];
  logic [31:0] lfsr = 32'hf889;
  int          n_mismatch = 0;
  int          tests_run = 0;
  wire logic   sda = (oe === 1'b1) ? sdo : m_sda;
  two_wire_eeprom_slave #(.PROG_CYCLES(PROG)) u_dut (.CLOCK_IN(clk), .RST_IN(rst),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sdo), .SDA_OE_OUT(oe),
    .CHIP_SELECT_STRAP_IN(strap), .WRITE_PROTECT_IN(wp), .BUSY_OUT(busy));
  two_wire_master u_m (.scl_out(scl), .sda_out(m_sda), .sda_in(sda), .obs_out(obs),
    .tgl_out(tgl));
  always #20 clk = ~clk;
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  // oldest note against each bus result
  always @(tgl) begin
    if ($time > 0) chk("bus", obs, exp_q.size() ? exp_q.pop_front() : 8'hxx);
  end
  task automatic sel(input logic [1:0] b, input logic rw, input logic [7:0] ack);
    exp_q.push_back(ack);
    u_m.start_c();
    u_m.tx({4'b1010, strap, b, rw});
  endtask : sel
  task automatic pre(input logic [9:0] a);
    sel(a[9:8], 1'b0, 8'h00);
    exp_q.push_back(8'h00);
    u_m.tx(a[7:0]);
  endtask : pre
  task automatic wr(input logic [9:0] a, input int n);
    logic [7:0] d;
    pre(a);
    for (int i = 0; i < n; i++) begin
      lfsr = nxt(lfsr);
      d = lfsr[7:0];
      exp_q.push_back(8'h00);
      u_m.tx(d);
      if (!wp) mem[{a[9:4], 4'(a[3:0] + i)}] = d;
    end
    u_m.stop_c();
  endtask : wr
  task automatic rd(input logic [9:0] a, input int n, input logic cur);
    if (!cur) pre(a); // dummy write
    sel(a[9:8], 1'b1, 8'h00);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(mem[10'(a + i)]);
      u_m.rx(i == n - 1);
    end
    u_m.stop_c();
  endtask : rd
  task automatic idle();
    for (int k = 0; busy !== 1'b0; k++) begin
      @(posedge clk);
      if (k > 600) begin
        chk("busy", {7'h00, busy}, 8'h00);
        report_and_stop();
      end
    end
    @(posedge clk);
    #1;
  endtask : idle
  initial begin
    lfsr = nxt(lfsr);
    strap = lfsr[0];
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    wr(10'h000, 1);
    repeat (3) @(posedge clk);
    #1;
    chk("busy", {7'h00, busy}, 8'h01);
    sel(2'b00, 1'b0, 8'h01);
    u_m.stop_c();
    idle();
    sel(2'b00, 1'b0, 8'h00);
    u_m.stop_c();
    $display("byte write test done");
    wr(10'h3fe, 18);
    idle();
    rd(10'h3f0, 16, 1'b0);
    rd(10'h000, 1, 1'b1);
    rd(10'h3ff, 2, 1'b0);
    $display("page and read test done");
    for (int i = 0; i < 2; i++) begin
      exp_q.push_back(8'h01);
      u_m.start_c();
      u_m.tx({3'b101, ~i[0], strap ^ i[0], 3'b000});
    end
    rd(10'h3ff, 1, 1'b0);
    @(posedge clk);
    #1 wp = 1'b1;
    wr(10'h000, 1);
    idle();
    rd(10'h000, 1, 1'b0);
    @(posedge clk);
    #1 wp = 1'b0;
    $display("refusal and protect test done");
    chk("left", 8'(exp_q.size()), 8'h00);
    report_and_stop();
  end
endmodule : tb_two_wire_eeprom_slave
